/* File: test_upac_pin_aux_config.sv */
`timescale 1ns/1ps
module test_upac_pin_aux_config
  import upac_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic tx_bit, tx_bit_start, baud16_en, rts_level, dtr_level, rx_bit, cts_level;
  logic [9:0] gpio_value, gpio_dir_out, gpio_o, gpio_oe, gpio_pullup, gpio_pulldown;
  logic dsr_level, tx_o, tx_oe, rx_i, rx_pullup, rx_pulldown, cts_i, dsr_i;
  logic clock_out, line_rx, tx_pin;
  logic [9:0] gpio_pin;
  logic [15:0] rd;
  logic [15:0] rstv [6] = '{16'h0080, 16'h07FF, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] mskv [6] = '{16'h0BFF, 16'h07FF, 16'h07FF, 16'h0007, 16'h0007, 16'hFFFF};
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  upac_pin_aux_config DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_bit, .tx_bit_start,
    .baud16_en, .rts_level, .dtr_level, .gpio_value, .gpio_dir_out, .rx_bit, .cts_level,
    .dsr_level, .tx_o, .tx_oe, .rx_i, .rx_pullup, .rx_pulldown, .cts_i, .dsr_i, .gpio_o,
    .gpio_oe, .gpio_pullup, .gpio_pulldown, .clock_out);
  upac_pin_load LOAD (.hclk, .tx_o, .tx_oe, .gpio_o, .gpio_oe, .gpio_pullup,
    .gpio_pulldown, .line_rx, .rx_i, .tx_pin, .gpio_pin);

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ----------
  // bus master and helpers
  // ----------
  task automatic bus(input logic w, input logic [7:0] i, input logic [15:0] d);
    haddr <= {22'h000000, i, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[15:0];
  endtask

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask

  task automatic run_len(input logic lv, output int k);
    k = 0;
    while (clock_out === lv)
    begin
      k++;
      @(posedge hclk);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      report_and_stop;
    end
  end

  // ----------
  // tests
  // ----------
  initial
  begin
    {hresetn, htrans, hwrite, tx_bit_start, baud16_en, rts_level, dtr_level} = '0;
    {haddr, hwdata, gpio_value, gpio_dir_out} = '0;
    {hsel, tx_bit, cts_i, dsr_i, line_rx} = '1;
    hsize = 3'b010;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      bus(1'b0, 8'(IDX_DRIVE + k), 16'h0000);
      chk("reset value", rstv[k], rd);
      chk("hresp", 16'h0000, 16'(hresp));
      bus(1'b1, 8'(IDX_DRIVE + k), mskv[k]);
      bus(1'b0, 8'(IDX_DRIVE + k), 16'h0000);
      chk("readback", mskv[k], rd);
    end
    bus(1'b0, 8'h12, 16'h0000);
    chk("unmapped", 16'h0000, rd);
    $display("registers done");
    // pull-up wins over pull-down, and pulls act only on inputs
    bus(1'b1, IDX_PULLUP, 16'h0155);
    bus(1'b1, IDX_PULLDN, 16'h07FF);
    cyc(2);
    chk("gpio_pin", 16'h0155, gpio_pin);
    chk("gpio_pulldown", 16'h02AA, gpio_pulldown);
    chk("rx_pulldown", 16'h0001, rx_pulldown);
    gpio_dir_out <= 10'h00F;
    bus(1'b1, IDX_PULLUP, 16'h07FF);
    cyc(2);
    chk("gpio_pullup", 16'h03F0, gpio_pullup);
    chk("rx_pulldown", 16'h0000, rx_pulldown);
    $display("pulls done");
    // push-pull against open drain on gpio and transmit pins
    bus(1'b1, IDX_LOOP, 16'h0000);
    bus(1'b1, IDX_INFRARED, 16'h0000);
    gpio_dir_out <= 10'h3FF;
    gpio_value <= 10'h0F0;
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, IDX_DRIVE, k ? 16'h0BFF : 16'h0000);
      cyc(2);
      chk("gpio_oe", k ? 16'h030F : 16'h03FF, gpio_oe);
      chk("gpio_o", k ? 16'h0000 : 16'h00F0, gpio_o & gpio_oe);
      for (int d = 0; d < 2; d++)
      begin
        tx_bit <= d[0];
        cyc(2);
        chk("tx_pin", 16'(d), tx_pin);
        chk("tx_oe", k ? 16'(!d) : 16'h0001, tx_oe);
      end
    end
    $display("drive done");
    // loops: every looped value is set opposite to its pin
    // push-pull again, so the transmit pin drives once the data loop is off
    bus(1'b1, IDX_DRIVE, 16'h0000);
    bus(1'b1, IDX_LOOP, 16'h0007);
    for (int v = 0; v < 3; v++)
    begin
      if (v == 2)
        bus(1'b1, IDX_LOOP, 16'h0000);
      else
        {rts_level, tx_bit, dsr_i, dtr_level, line_rx, cts_i} <= {{3{v[0]}}, {3{!v[0]}}};
      cyc(8);
      chk("cts_level", v == 2 ? 16'h0000 : 16'(v), cts_level);
      chk("dsr_level", v == 2 ? 16'h0001 : 16'(v == 0), dsr_level);
      chk("rx_bit", v == 2 ? 16'h0000 : 16'(v), rx_bit);
      chk("tx_oe", v == 2 ? 16'h0001 : 16'h0000, tx_oe);
    end
    $display("loopback done");
    // infrared: one pulse per zero bit, 3 or 4 ticks wide
    baud16_en <= 1'b1;
    for (int w = 0; w < 2; w++)
    begin
      bus(1'b1, IDX_INFRARED, {13'h0000, w[0], 2'b01});
      for (int d = 0; d < 2; d++)
      begin
        tx_bit <= d[0];
        tx_bit_start <= 1'b1;
        @(posedge hclk);
        tx_bit_start <= 1'b0;
        n = 0;
        repeat (40) @(posedge hclk) n += (tx_o === 1'b1);
        chk("pulse", d ? 16'h0000 : 16'(3 + w), 16'(n));
      end
    end
    cyc(8);
    chk("ir idle", 16'h0001, rx_bit);
    line_rx <= 1'b1;
    cyc(3);
    line_rx <= 1'b0;
    cyc(8);
    chk("ir pulse", 16'h0000, rx_bit);
    cyc(30);
    chk("ir after", 16'h0001, rx_bit);
    bus(1'b1, IDX_INFRARED, 16'h0002);
    for (int b = 0; b < 2; b++)
    begin
      line_rx <= b[0];
      cyc(8);
      chk("rx invert", 16'(!b), rx_bit);
    end
    $display("infrared done");
    // 3 high and 2 low intervals of 41.67 ns: 6-7 and 4-5 cycles
    bus(1'b1, IDX_CLKDIV, 16'h0302);
    cyc(30);
    while (clock_out !== 1'b1) @(posedge hclk);
    run_len(1'b1, n);
    chk("high time", 16'h0001, 16'(n >= 6 && n <= 7));
    run_len(1'b0, n);
    chk("low time", 16'h0001, 16'(n >= 4 && n <= 5));
    bus(1'b1, IDX_CLKDIV, 16'h0000);
    cyc(4);
    n = 0;
    repeat (20) @(posedge hclk) n += (clock_out !== 1'b0);
    chk("clock off", 16'h0000, 16'(n));
    // filtered pins: rx high, cts low, dsr high, clock held low
    bus(1'b0, IDX_STATUS, 16'h0000);
    chk("status", 16'h0005, rd);
    $display("clock done");
    report_and_stop;
  end
endmodule // test_upac_pin_aux_config

/* File: upac_checker.sv */
`timescale 1ns/1ps
module upac_checker
  import upac_pkg::*;
#(
  parameter int GPIO_N = 10
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // engine side
  input wire logic tx_bit,
  input wire logic rts_level,
  input wire logic dtr_level,
  input wire logic [GPIO_N-1:0] gpio_value,
  input wire logic [GPIO_N-1:0] gpio_dir_out,
  input wire logic cts_level,
  input wire logic dsr_level,
  // pads
  input wire logic tx_o,
  input wire logic tx_oe,
  input wire logic rx_pullup,
  input wire logic rx_pulldown,
  input wire logic [GPIO_N-1:0] gpio_oe,
  input wire logic [GPIO_N-1:0] gpio_pullup,
  input wire logic [GPIO_N-1:0] gpio_pulldown,
  input wire logic clock_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------
  // register shadow, loaded at the same edge as the block's own
  // ----------
  logic wr_r;
  logic [7:0] idx_r;
  logic [15:0] dr_r, pu_r, pd_r, lp_r, ir_r, ck_r;
  wire [GPIO_N-1:0] pu_in = pu_r[GPIO_N-1:0] & ~gpio_dir_out;
  wire [GPIO_N-1:0] pd_in = pd_r[GPIO_N-1:0] & ~pu_r[GPIO_N-1:0] & ~gpio_dir_out;
  wire [GPIO_N-1:0] oe_want = gpio_dir_out & ~(dr_r[GPIO_N-1:0] & gpio_value);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_r <= 1'b0;
      idx_r <= 8'h00;
      dr_r <= RST_DRIVE;
      pu_r <= RST_PULLUP;
      {pd_r, lp_r, ir_r, ck_r} <= '0;
    end
    else
    begin
      wr_r <= hsel & htrans[1] & hready & hwrite;
      idx_r <= haddr[9:2];
      if (wr_r && idx_r == IDX_DRIVE) dr_r <= hwdata[15:0] & MSK_DRIVE;
      if (wr_r && idx_r == IDX_PULLUP) pu_r <= hwdata[15:0] & MSK_PULL;
      if (wr_r && idx_r == IDX_PULLDN) pd_r <= hwdata[15:0] & MSK_PULL;
      if (wr_r && idx_r == IDX_LOOP) lp_r <= hwdata[15:0] & MSK_LOOP;
      if (wr_r && idx_r == IDX_INFRARED) ir_r <= hwdata[15:0] & MSK_INFRARED;
      if (wr_r && idx_r == IDX_CLKDIV) ck_r <= hwdata[15:0];
    end
  end

  // ----------
  // pad relations, one cycle behind the register and engine inputs
  // ----------
  pullup_gpio_a: assert property ($past(hresetn) |->
    gpio_pullup == $past(pu_in)) else $error("gpio pull-up wrong");
  pulldn_gpio_a: assert property ($past(hresetn) |->
    gpio_pulldown == $past(pd_in)) else $error("gpio pull-down wrong");
  rx_pull_a: assert property ($past(hresetn) |-> rx_pullup == $past(pu_r[10])
    && rx_pulldown == $past(pd_r[10] & ~pu_r[10])) else $error("rx pulls wrong");
  gpio_drive_a: assert property ($past(hresetn) |->
    gpio_oe == $past(oe_want)) else $error("gpio enable wrong");
  tx_drive_a: assert property ($past(hresetn && !lp_r[0] && !ir_r[0]) |->
    tx_oe == ($past(dr_r[11]) ? !$past(tx_bit) : 1'b1)) else $error("tx enable wrong");
  loop_tx_a: assert property ($past(hresetn && lp_r[0]) |->
    !tx_oe) else $error("tx pin not released");
  loop_cts_a: assert property ($past(hresetn && lp_r[1]) |->
    cts_level == $past(rts_level)) else $error("cts not looped");
  loop_dsr_a: assert property ($past(hresetn && lp_r[2]) |->
    dsr_level == $past(dtr_level)) else $error("dsr not looped");
  clock_off_a: assert property ((ck_r == 16'h0000) [*3] |->
    !clock_out) else $error("clock out not held");

  loop_seen_c: cover property (lp_r[0] && !tx_bit);
  clk_rise_c: cover property ($rose(clock_out));
  ir_pulse_c: cover property (ir_r[0] && tx_o);
endmodule // upac_checker

bind upac_pin_aux_config upac_checker #(.GPIO_N(GPIO_N)) u_checker (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .tx_bit,
  .rts_level, .dtr_level, .gpio_value, .gpio_dir_out, .cts_level, .dsr_level,
  .tx_o, .tx_oe, .rx_pullup, .rx_pulldown, .gpio_oe, .gpio_pullup, .gpio_pulldown,
  .clock_out
);

/* File: upac_pin_aux_config.sv */
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
module upac_pin_aux_config
  import upac_pkg::*;
#(
  parameter int GPIO_N = 10
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial engine side
  input wire logic tx_bit,
  input wire logic tx_bit_start,
  input wire logic baud16_en,
  input wire logic rts_level,
  input wire logic dtr_level,
  input wire logic [GPIO_N-1:0] gpio_value,
  input wire logic [GPIO_N-1:0] gpio_dir_out,
  output logic rx_bit,
  output logic cts_level,
  output logic dsr_level,
  // serial pins
  output logic tx_o,
  output logic tx_oe,
  input wire logic rx_i,
  output logic rx_pullup,
  output logic rx_pulldown,
  input wire logic cts_i,
  input wire logic dsr_i,
  // general-purpose pins
  output logic [GPIO_N-1:0] gpio_o,
  output logic [GPIO_N-1:0] gpio_oe,
  output logic [GPIO_N-1:0] gpio_pullup,
  output logic [GPIO_N-1:0] gpio_pulldown,
  // generated clock
  output logic clock_out
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_pend_r;
  logic [IDX_W-1:0] wr_idx_r;
  logic [31:0] hrdata_r;
  logic [REG_W-1:0] drive_r, pullup_r, pulldn_r, loop_r, infrared_r, clkdiv_r;
  logic [REG_W-1:0] drive_nxt, pullup_nxt, pulldn_nxt, loop_nxt, infrared_nxt, clkdiv_nxt;
  logic [REG_W-1:0] status_word;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] rd_mux;

  wire access = hsel && htrans[1] && hready;
  wire [IDX_W-1:0] addr_idx = haddr[IDX_W+1:2];
  wire rd_req = access && !hwrite;
  assign wdata = hwdata[REG_W-1:0];

  // a write lands in its data phase; the reads below look at the next
  // values so a read right behind a write sees the new contents
  wire wr_drive = wr_pend_r && (wr_idx_r == IDX_DRIVE);
  wire wr_pullup = wr_pend_r && (wr_idx_r == IDX_PULLUP);
  wire wr_pulldn = wr_pend_r && (wr_idx_r == IDX_PULLDN);
  wire wr_loop = wr_pend_r && (wr_idx_r == IDX_LOOP);
  wire wr_infrared = wr_pend_r && (wr_idx_r == IDX_INFRARED);
  wire wr_clkdiv = wr_pend_r && (wr_idx_r == IDX_CLKDIV);

  // reserved bits are masked off, so a stray one is never stored
  assign drive_nxt = wr_drive ? (wdata & MSK_DRIVE) : drive_r;
  assign pullup_nxt = wr_pullup ? (wdata & MSK_PULL) : pullup_r;
  assign pulldn_nxt = wr_pulldn ? (wdata & MSK_PULL) : pulldn_r;
  assign loop_nxt = wr_loop ? (wdata & MSK_LOOP) : loop_r;
  assign infrared_nxt = wr_infrared ? (wdata & MSK_INFRARED) : infrared_r;
  assign clkdiv_nxt = wr_clkdiv ? (wdata & MSK_CLKDIV) : clkdiv_r;

  assign rd_mux = (addr_idx == IDX_DRIVE) ? drive_nxt :
                  (addr_idx == IDX_PULLUP) ? pullup_nxt :
                  (addr_idx == IDX_PULLDN) ? pulldn_nxt :
                  (addr_idx == IDX_LOOP) ? loop_nxt :
                  (addr_idx == IDX_INFRARED) ? infrared_nxt :
                  (addr_idx == IDX_CLKDIV) ? clkdiv_nxt :
                  (addr_idx == IDX_STATUS) ? status_word : 16'h0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end
    else
    begin
      wr_pend_r <= access && hwrite;
      if (access)
      begin
        wr_idx_r <= addr_idx;
      end
      if (rd_req)
      begin
        hrdata_r <= {16'h0000, rd_mux};
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      drive_r <= RST_DRIVE;
      pullup_r <= RST_PULLUP;
      pulldn_r <= RST_PULLDN;
      loop_r <= RST_LOOP;
      infrared_r <= RST_INFRARED;
      clkdiv_r <= RST_CLKDIV;
    end
    else
    begin
      drive_r <= drive_nxt;
      pullup_r <= pullup_nxt;
      pulldn_r <= pulldn_nxt;
      loop_r <= loop_nxt;
      infrared_r <= infrared_nxt;
      clkdiv_r <= clkdiv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin input synchronisers: rx, cts, dsr
  // ----------------------------------------------------------------
  logic [2:0] sync1_r, sync2_r, sync3_r, pin_r;
  wire [2:0] pin_raw = {dsr_i, cts_i, rx_i};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      sync3_r <= 3'h7;
      pin_r <= 3'h7;
    end
    else
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      // a change is taken only once two stages agree, rejecting glitches
      pin_r <= (sync2_r & sync3_r) | (pin_r & (sync2_r ^ sync3_r));
    end
  end

  // ----------------------------------------------------------------
  // infrared transmit encoder
  // ----------------------------------------------------------------
  logic [3:0] tx_tick_r;
  wire ir_on = infrared_r[IR_EN_BIT];
  wire [3:0] ir_width = infrared_r[IR_WIDE_BIT] ? IR_WIDE_TICKS : IR_NARROW_TICKS;
  wire ir_pulse = !tx_bit && (tx_tick_r < ir_width);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_tick_r <= 4'hF;
    end
    else if (tx_bit_start)
    begin
      tx_tick_r <= 4'h0;
    end
    else if (baud16_en && tx_tick_r != 4'hF)
    begin
      tx_tick_r <= tx_tick_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // receive path: inversion, infrared decode, loopback
  // ----------------------------------------------------------------
  logic [4:0] rx_hold_r;
  wire rx_pin = pin_r[0] ^ infrared_r[IR_INV_BIT];

  // an infrared pulse marks a zero; stretch it over one bit so the
  // receiver sees a normal level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_hold_r <= 5'h00;
    end
    else if (ir_on && rx_pin)
    begin
      rx_hold_r <= TICKS_PER_BIT;
    end
    else if (baud16_en && rx_hold_r != 5'h00)
    begin
      rx_hold_r <= rx_hold_r - 5'h01;
    end
  end

  wire rx_decoded = ir_on ? (rx_hold_r == 5'h00) : rx_pin;
  wire data_loop = loop_r[LOOP_DATA_BIT];
  wire rx_nxt = data_loop ? tx_bit : rx_decoded;
  wire cts_nxt = loop_r[LOOP_RTS_BIT] ? rts_level : pin_r[1];
  wire dsr_nxt = loop_r[LOOP_DTR_BIT] ? dtr_level : pin_r[2];

  // ----------------------------------------------------------------
  // transmit pad driver
  // ----------------------------------------------------------------
  wire tx_line = ir_on ? ir_pulse : tx_bit;
  wire tx_od = drive_r[TX_OD_BIT];
  wire tx_o_nxt = tx_od ? 1'b0 : tx_line;
  // in data loopback the pin is released entirely
  wire tx_oe_nxt = !data_loop && (tx_od ? !tx_line : 1'b1);

  // ----------------------------------------------------------------
  // general-purpose pad drivers and pulls
  // ----------------------------------------------------------------
  logic [GPIO_N-1:0] gp_o_nxt, gp_oe_nxt, gp_pu_nxt, gp_pd_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < GPIO_N; gi++)
    begin : g_pad
      // open drain only ever pulls low and floats for a one
      assign gp_o_nxt[gi] = drive_r[gi] ? 1'b0 : gpio_value[gi];
      assign gp_oe_nxt[gi] = gpio_dir_out[gi] && (drive_r[gi] ? !gpio_value[gi] : 1'b1);
      assign gp_pu_nxt[gi] = pullup_r[gi] && !gpio_dir_out[gi];
      assign gp_pd_nxt[gi] = pulldn_r[gi] && !pullup_r[gi] && !gpio_dir_out[gi];
    end
  endgenerate

  wire rx_pu_nxt = pullup_r[RX_PULL_BIT];
  wire rx_pd_nxt = pulldn_r[RX_PULL_BIT] && !pullup_r[RX_PULL_BIT];

  // ----------------------------------------------------------------
  // clock output generator
  // ----------------------------------------------------------------
  logic [PHASE_W-1:0] phase_r;
  logic [7:0] ck_cnt_r;
  logic ck_level_r;
  upac_ck_state_t ck_state_r, ck_state_nxt;

  wire [7:0] high_count = clkdiv_r[HIGH_MSB:HIGH_LSB];
  wire [7:0] low_count = clkdiv_r[LOW_MSB:LOW_LSB];
  wire ck_off = (high_count == 8'h00) && (low_count == 8'h00);
  // a zero count alone is stretched to one interval
  wire [7:0] high_len = (high_count == 8'h00) ? 8'h01 : high_count;
  wire [7:0] low_len = (low_count == 8'h00) ? 8'h01 : low_count;
  // phase accumulator turns the 20 ns clock into 41.67 ns interval ticks
  wire [PHASE_W-1:0] phase_sum = phase_r + PHASE_STEP;
  wire unit_tick = phase_sum >= PHASE_WRAP;
  wire ck_done = unit_tick && (ck_cnt_r == 8'h01);

  always_comb
  begin
    ck_state_nxt = ck_state_r;
    unique case (ck_state_r)
      CK_OFF:
        ck_state_nxt = ck_off ? CK_OFF : CK_LOW;
      CK_LOW:
        ck_state_nxt = ck_off ? CK_OFF : (ck_done ? CK_HIGH : CK_LOW);
      CK_HIGH:
        ck_state_nxt = ck_off ? CK_OFF : (ck_done ? CK_LOW : CK_HIGH);
      default:
        ck_state_nxt = CK_OFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_r <= '0;
      ck_state_r <= CK_OFF;
      ck_cnt_r <= 8'h00;
    end
    else
    begin
      phase_r <= unit_tick ? phase_sum - PHASE_WRAP : phase_sum;
      ck_state_r <= ck_state_nxt;
      if (ck_state_nxt != ck_state_r)
      begin
        ck_cnt_r <= (ck_state_nxt == CK_HIGH) ? high_len : low_len;
      end
      else if (unit_tick && ck_cnt_r != 8'h01)
      begin
        ck_cnt_r <= ck_cnt_r - 8'h01;
      end
    end
  end

  assign status_word = {12'h000, ck_level_r, pin_r};

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_o <= 1'b1;
      tx_oe <= 1'b0;
      rx_bit <= 1'b1;
      cts_level <= 1'b1;
      dsr_level <= 1'b1;
      rx_pullup <= 1'b1;
      rx_pulldown <= 1'b0;
      gpio_o <= '0;
      gpio_oe <= '0;
      gpio_pullup <= '0;
      gpio_pulldown <= '0;
      ck_level_r <= 1'b0;
    end
    else
    begin
      tx_o <= tx_o_nxt;
      tx_oe <= tx_oe_nxt;
      rx_bit <= rx_nxt;
      cts_level <= cts_nxt;
      dsr_level <= dsr_nxt;
      rx_pullup <= rx_pu_nxt;
      rx_pulldown <= rx_pd_nxt;
      gpio_o <= gp_o_nxt;
      gpio_oe <= gp_oe_nxt;
      gpio_pullup <= gp_pu_nxt;
      gpio_pulldown <= gp_pd_nxt;
      ck_level_r <= (ck_state_nxt == CK_HIGH);
    end
  end

  assign clock_out = ck_level_r;
  assign hrdata = hrdata_r;
  // zero-wait slave that never errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule // upac_pin_aux_config

/* File: upac_pin_load.sv */
`timescale 1ns/1ps
module upac_pin_load
(
  // clock
  input wire logic hclk,
  // pad controls from the block
  input wire logic tx_o,
  input wire logic tx_oe,
  input wire logic [9:0] gpio_o,
  input wire logic [9:0] gpio_oe,
  input wire logic [9:0] gpio_pullup,
  input wire logic [9:0] gpio_pulldown,
  // far-side levels
  input wire logic line_rx,
  output logic rx_i,
  output logic tx_pin,
  output logic [9:0] gpio_pin
);
  // a pin nobody drives or pulls shows a level that changes every cycle
  logic flt_r = 1'b0;
  always @(posedge hclk) flt_r <= ~flt_r;
  // the remote end pulls the transmit line up, so a released pin reads high
  assign tx_pin = tx_oe ? tx_o : 1'b1;
  assign rx_i = line_rx;
  assign gpio_pin = (gpio_oe & gpio_o) |
    (~gpio_oe & (gpio_pullup | (~gpio_pulldown & {10{flt_r}})));
endmodule // upac_pin_load

/* File: upac_pkg.sv */
package upac_pkg;

  // ----------------------------------------------------------------
  // register map: printed offsets are word indices, byte address = 4 * index
  // ----------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_DRIVE = 8'h13;
  localparam logic [IDX_W-1:0] IDX_PULLUP = 8'h14;
  localparam logic [IDX_W-1:0] IDX_PULLDN = 8'h15;
  localparam logic [IDX_W-1:0] IDX_LOOP = 8'h16;
  localparam logic [IDX_W-1:0] IDX_INFRARED = 8'h17;
  localparam logic [IDX_W-1:0] IDX_CLKDIV = 8'h18;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h19;

  // ----------------------------------------------------------------
  // reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_DRIVE = 16'h0080;
  localparam logic [REG_W-1:0] RST_PULLUP = 16'h07FF;
  localparam logic [REG_W-1:0] RST_PULLDN = 16'h0000;
  localparam logic [REG_W-1:0] RST_LOOP = 16'h0000;
  localparam logic [REG_W-1:0] RST_INFRARED = 16'h0000;
  localparam logic [REG_W-1:0] RST_CLKDIV = 16'h0000;
  localparam logic [REG_W-1:0] MSK_DRIVE = 16'h0BFF;
  localparam logic [REG_W-1:0] MSK_PULL = 16'h07FF;
  localparam logic [REG_W-1:0] MSK_LOOP = 16'h0007;
  localparam logic [REG_W-1:0] MSK_INFRARED = 16'h0007;
  localparam logic [REG_W-1:0] MSK_CLKDIV = 16'hFFFF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TX_OD_BIT = 11;
  localparam int RX_PULL_BIT = 10;
  localparam int LOOP_DTR_BIT = 2;
  localparam int LOOP_RTS_BIT = 1;
  localparam int LOOP_DATA_BIT = 0;
  localparam int IR_WIDE_BIT = 2;
  localparam int IR_INV_BIT = 1;
  localparam int IR_EN_BIT = 0;
  localparam int HIGH_MSB = 15;
  localparam int HIGH_LSB = 8;
  localparam int LOW_MSB = 7;
  localparam int LOW_LSB = 0;

  // ----------------------------------------------------------------
  // infrared pulse widths in 1/16 bit ticks
  // ----------------------------------------------------------------
  localparam logic [3:0] IR_NARROW_TICKS = 4'h3;
  localparam logic [3:0] IR_WIDE_TICKS = 4'h4;
  localparam logic [4:0] TICKS_PER_BIT = 5'h10;

  // ----------------------------------------------------------------
  // clock output timing, phase kept in units of 10 ps
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 20.0;
  localparam real CLOCK_OUT_DIVIDER_UNIT_NS = 41.67;
  localparam int PHASE_W = 13;
  localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(int'(CLK_PERIOD_NS * 100.0));
  localparam logic [PHASE_W-1:0] PHASE_WRAP = PHASE_W'(int'(CLOCK_OUT_DIVIDER_UNIT_NS * 100.0));

  typedef enum logic [1:0] {
    CK_OFF = 2'b00,
    CK_LOW = 2'b01,
    CK_HIGH = 2'b11
  } upac_ck_state_t;

endpackage
